// [tx_frame_map.svh]
// Constants for the transmit framing path: characters, sizes, CRC, gap.
// Assumes an 8-byte client word and a byte-serial PCS-side stream.
`ifndef TX_FRAME_MAP_SVH
`define TX_FRAME_MAP_SVH
`define TX_WORD_BYTES 8
`define TX_IDLE_CHAR 8'h07
`define TX_START_CHAR 8'hFB
`define TX_PRE_CHAR 8'h55
`define TX_SFD_CHAR 8'hD5
`define TX_TERM_CHAR 8'hFD
`define TX_ERR_CHAR 8'hFE
`define TX_PAD_BYTE 8'h00
`define TX_PRE_BYTES 16'h0008
`define TX_MIN_FRAME 16'h0040
`define TX_FCS_BYTES 16'h0004
`define TX_TYPE_MIN 16'h0600
`define TX_MAX_LEN 16'h05DC
`define TX_CRC_POLY 32'hEDB88320
`define TX_CRC_INIT 32'hFFFFFFFF
`define TX_GAP_STD 12
`define TX_GAP_REDUCED 8
`define TX_GAP_OFF 0
`define TX_LANE_SPAN 6'h03
`endif

// [tx_frame_pkg.sv]
// Types shared by the transmit framing ends.
// Assumes tx_frame_map.svh for the numeric constants.
package tx_frame_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE = 3'b001,
    ST_DATA = 3'b010,
    ST_PAD = 3'b011,
    ST_CRC = 3'b100,
    ST_TERM = 3'b101,
    ST_ERR = 3'b110
  } enc_state_e;

  typedef struct packed {
    logic [63:0] data;
    logic sop;
    logic eop;
    logic [2:0] empty;
    logic error;
  } client_word_s;
endpackage : tx_frame_pkg

// [tx_client_if.sv]
// Client packet stream between the packet source and the framing end.
// Assumes one clock; ready latency zero.
`timescale 1ns/10ps
interface tx_client_if;
  logic valid;
  logic ready;
  logic [63:0] data;
  logic sop;
  logic eop;
  logic [2:0] empty;
  logic error;
  modport source (output valid, output data, output sop, output eop, output empty,
    output error, input ready);
  modport sink (input valid, input data, input sop, input eop, input empty,
    input error, output ready);
endinterface : tx_client_if

// [word_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 70,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
    logic full;
  } fifo_s;
  fifo_s s_r, s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = !s_r.full;
  assign out_valid = (s_r.count != '0);
  assign out_data = mem[s_r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) s_nxt.wr = (s_r.wr == PW'(DEPTH-1)) ? '0 : s_r.wr + 1'b1;
    if (pop) s_nxt.rd = (s_r.rd == PW'(DEPTH-1)) ? '0 : s_r.rd + 1'b1;
    if (push && !pop) s_nxt.count = s_r.count + 1'b1;
    else if (pop && !push) s_nxt.count = s_r.count - 1'b1;
    // Full kept in a register so ready leaves the block straight from a flop
    s_nxt.full = (s_nxt.count == (PW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (rst) s_r <= '0;
    else s_r <= s_nxt;
    if (push) mem[s_r.wr] <= in_data;
  end
endmodule : word_fifo

// [tx_mac_frame_encapsulator.sv]
// Transmit framing end: takes client words, emits a byte-serial framed stream.
// Assumes the client keeps its side of the stream contract; one clock.
`timescale 1ns/10ps
`include "tx_frame_map.svh"
// Summary of operation
// (R01) Prepend start byte plus preamble unless pass-through
// (R02) Pass-through client supplies whole preamble itself
// (R03) Addresses and payload forwarded byte for byte
// (R04) Length/type field passed through unaltered
// (R05) Zero-pad short frames up to 64 bytes
// (R06) Client never sends frames under nine bytes
// (R07) CRC covers addresses through pad only
// (R08) CRC uses standard Ethernet generator polynomial
// (R09) CRC sent highest-order coefficient first
// (R10) CRC insertion is build option, default on
// (R11) Without CRC insertion client supplies CRC, 64+
// (R12) Standard gap: deficit counter keeps 12-byte average
// (R13) Reduced gap: deficit counter keeps 8-byte average
// (R14) Counter disabled: send at once, 1-byte gap
// (R15) Packet bus error flag raised at end cycle
// (R16) Lane error bit pairs with lane end bit
// (R17) Errored frame ends in eight error characters
// (R18) Ready latency zero: accepted when ready high
// (R19) Client sends packet words back to back
// (R20) Start of packet sits in top byte
// (R21) CRC preset ones, reflected, final complement
module tx_mac_frame_encapsulator import tx_frame_pkg::*; #(
  parameter bit PREAMBLE_PASS = 1'b0,
  parameter bit CRC_INSERT = 1'b1,
  parameter bit FLOW_CONTROL = 1'b0,
  parameter int GAP_MODE = `TX_GAP_STD,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  tx_client_if.sink cli,
  output logic [7:0] pcs_byte,
  output logic pcs_ctl
);
  typedef struct packed {
    enc_state_e st;
    logic [2:0] idx;
    logic [2:0] k;
    logic [15:0] cnt;
    logic [31:0] crc;
    logic [3:0] gap;
    logic [1:0] lag;
    logic [1:0] lane;
    logic [7:0] byte_o;
    logic ctl_o;
  } enc_s;

  localparam bit CRC_ON = CRC_INSERT || FLOW_CONTROL; // [R10]
  localparam logic [15:0] PRE_LEN = PREAMBLE_PASS ? `TX_PRE_BYTES : 16'h0000;
  localparam logic [15:0] PAD_TO = `TX_MIN_FRAME - `TX_FCS_BYTES;
  localparam logic [5:0] GAP_BYTES = 6'(GAP_MODE);

  enc_s s_r, s_nxt;
  client_word_s f_word;
  logic f_valid, pop;
  logic [7:0] cur;
  logic [2:0] sh;
  logic last_here, counted, start_ok;
  logic [15:0] len;
  logic [5:0] need, have;
  logic [31:0] fcs;

  // Reflected byte-wise update, least significant data bit first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `TX_CRC_POLY) : (r >> 1); // [R08] [R21]
    end
    return r;
  endfunction : crc_byte

  word_fifo #(.WIDTH($bits(client_word_s)), .DEPTH(FIFO_DEPTH)) i_word_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(cli.valid),
    .in_ready(cli.ready), // [R18]
    .in_data({cli.data, cli.sop, cli.eop, cli.empty, cli.error}),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_word)
  );

  assign pcs_byte = s_r.byte_o;
  assign pcs_ctl = s_r.ctl_o;

  always_comb begin
    sh = 3'h7 - s_r.idx;
    cur = f_word.data[{sh, 3'b000} +: 8]; // [R20]
    last_here = f_word.eop && (s_r.idx == (3'h7 - f_word.empty));
    counted = (s_r.cnt >= PRE_LEN);
    len = s_r.cnt - PRE_LEN;
    fcs = ~s_r.crc; // [R21]
    need = GAP_BYTES + {4'h0, s_r.lag};
    have = {2'b00, s_r.gap};
    if (GAP_MODE == `TX_GAP_OFF) begin
      start_ok = (s_r.gap != 4'h0); // [R14]
    end else begin
      start_ok = (s_r.lane == 2'b00) && (have + `TX_LANE_SPAN >= need); // [R12] [R13]
    end
  end

  always_comb begin
    s_nxt = s_r;
    pop = 1'b0;
    s_nxt.lane = s_r.lane + 2'b01;
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.byte_o = `TX_IDLE_CHAR;
        s_nxt.ctl_o = 1'b1;
        if (s_r.gap != 4'hF) s_nxt.gap = s_r.gap + 4'h1;
        if (f_valid && !f_word.sop) begin
          pop = 1'b1;
        end else if (f_valid && start_ok) begin
          s_nxt.crc = `TX_CRC_INIT; // [R21]
          s_nxt.k = 3'h0;
          // Shortage carried to the next gap keeps the long-run average
          s_nxt.lag = (have >= need) ? 2'b00 : 2'(need - have); // [R12] [R13]
          if (PREAMBLE_PASS) begin
            s_nxt.byte_o = cur; // [R02]
            s_nxt.idx = 3'h1;
            s_nxt.cnt = 16'h0001;
            s_nxt.st = ST_DATA;
          end else begin
            s_nxt.byte_o = `TX_START_CHAR; // [R01]
            s_nxt.idx = 3'h0;
            s_nxt.cnt = 16'h0000;
            s_nxt.st = ST_PRE;
          end
        end
      end
      ST_PRE: begin
        s_nxt.ctl_o = 1'b0;
        s_nxt.byte_o = (s_r.k == 3'h6) ? `TX_SFD_CHAR : `TX_PRE_CHAR; // [R01]
        s_nxt.k = s_r.k + 3'h1;
        if (s_r.k == 3'h6) s_nxt.st = ST_DATA;
      end
      ST_DATA: begin
        if (!f_valid) begin
          // Underrun corrupts the frame visibly instead of stalling the link
          s_nxt.byte_o = `TX_ERR_CHAR;
          s_nxt.ctl_o = 1'b1;
        end else begin
          s_nxt.byte_o = cur; // [R03] [R04]
          s_nxt.ctl_o = 1'b0;
          if (counted && CRC_ON) s_nxt.crc = crc_byte(s_r.crc, cur); // [R07]
          s_nxt.cnt = s_r.cnt + 16'h0001;
          s_nxt.idx = s_r.idx + 3'h1;
          s_nxt.k = 3'h0;
          if (last_here) begin
            pop = 1'b1;
            s_nxt.idx = 3'h0;
            if (f_word.error) s_nxt.st = ST_ERR; // [R17]
            else if (!CRC_ON) s_nxt.st = ST_TERM;
            else if (len + 16'h0001 < PAD_TO) s_nxt.st = ST_PAD; // [R05]
            else s_nxt.st = ST_CRC;
          end else if (s_r.idx == 3'h7) begin
            pop = 1'b1;
          end
        end
      end
      ST_PAD: begin
        s_nxt.byte_o = `TX_PAD_BYTE; // [R05]
        s_nxt.ctl_o = 1'b0;
        s_nxt.crc = crc_byte(s_r.crc, `TX_PAD_BYTE); // [R07]
        s_nxt.cnt = s_r.cnt + 16'h0001;
        if (len + 16'h0001 == PAD_TO) s_nxt.st = ST_CRC;
      end
      ST_CRC: begin
        s_nxt.byte_o = fcs[{s_r.k[1:0], 3'b000} +: 8]; // [R09]
        s_nxt.ctl_o = 1'b0;
        s_nxt.k = s_r.k + 3'h1;
        if (s_r.k == 3'h3) s_nxt.st = ST_TERM;
      end
      ST_TERM: begin
        s_nxt.byte_o = `TX_TERM_CHAR;
        s_nxt.ctl_o = 1'b1;
        s_nxt.gap = 4'h1;
        s_nxt.st = ST_IDLE;
      end
      ST_ERR: begin
        s_nxt.byte_o = `TX_ERR_CHAR; // [R17]
        s_nxt.ctl_o = 1'b1;
        s_nxt.k = s_r.k + 3'h1;
        if (s_r.k == 3'h7) begin
          s_nxt.gap = 4'h1;
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.byte_o <= `TX_IDLE_CHAR;
      s_r.ctl_o <= 1'b1;
      s_r.gap <= 4'hF;
      s_r.crc <= `TX_CRC_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : tx_mac_frame_encapsulator

// [tx_packet_source.sv]
// Client end: registers user words onto the client stream.
// Assumes user logic holds whole packets ready before raising start.
`timescale 1ns/10ps
`include "tx_frame_map.svh"
module tx_packet_source import tx_frame_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [63:0] in_data,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [2:0] in_empty,
  input wire logic in_error,
  tx_client_if.source cli
);
  typedef struct packed {
    logic valid;
    client_word_s w;
  } src_s;
  src_s s_r, s_nxt;
  logic take;

  assign in_ready = !s_r.valid || cli.ready; // [R18]
  assign take = in_valid && in_ready;
  assign cli.valid = s_r.valid;
  assign cli.data = s_r.w.data; // [R20] [R02] [R11]
  assign cli.sop = s_r.w.sop;
  assign cli.eop = s_r.w.eop;
  assign cli.empty = s_r.w.empty;
  assign cli.error = s_r.w.error;

  always_comb begin
    s_nxt = s_r;
    if (s_r.valid && cli.ready) s_nxt.valid = 1'b0; // [R18]
    // A packet of one word is at most eight bytes and is dropped
    if (take && !(in_sop && in_eop)) begin // [R06]
      s_nxt.valid = 1'b1; // [R19]
      s_nxt.w.data = in_data;
      s_nxt.w.sop = in_sop;
      s_nxt.w.eop = in_eop;
      s_nxt.w.empty = in_eop ? in_empty : 3'h0;
      s_nxt.w.error = in_error && in_eop; // [R15] [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) s_r <= '0;
    else s_r <= s_nxt;
  end
endmodule : tx_packet_source

// [tx_frame_monitor.sv]
// Checker for the client link and the byte-serial framed stream.
// Assumes the standard gap setting and no preamble pass-through.
`timescale 1ns/10ps
`include "tx_frame_map.svh"
module tx_frame_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic valid,
  input wire logic ready,
  input wire logic [63:0] data,
  input wire logic sop,
  input wire logic eop,
  input wire logic [2:0] empty,
  input wire logic error,
  input wire logic [7:0] pcs_byte,
  input wire logic pcs_ctl
);
  logic fb_w;
  logic fd_w;
  logic fe_w;
  logic idle_w;
  logic sfd_w;
  logic ctl_ok_w;
  logic [69:0] word_w;
  assign fb_w = pcs_ctl && pcs_byte == `TX_START_CHAR;
  assign fd_w = pcs_ctl && pcs_byte == `TX_TERM_CHAR;
  assign fe_w = pcs_ctl && pcs_byte == `TX_ERR_CHAR;
  assign idle_w = pcs_ctl && pcs_byte == `TX_IDLE_CHAR;
  assign sfd_w = !pcs_ctl && pcs_byte == `TX_SFD_CHAR;
  assign ctl_ok_w = idle_w || fb_w || fd_w || fe_w;
  assign word_w = {data, sop, eop, empty, error};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence pre_s;
    (!pcs_ctl && pcs_byte == `TX_PRE_CHAR)[*6] ##1 sfd_w;
  endsequence
  sequence err_s;
    fe_w[*7] ##1 idle_w;
  endsequence
  a_start_preamble: assert property (fb_w |=> pre_s)
    else $error("start not followed by preamble");
  a_hold_word: assert property (valid && !ready |=> valid && $stable(word_w))
    else $error("client word changed before taken");
  a_error_block: assert property ($rose(fe_w) |=> err_s)
    else $error("error block not eight characters");
  a_term_gap: assert property (fd_w |=> !fb_w [*7])
    else $error("gap after terminate too short");
  a_term_idle: assert property (fd_w |=> idle_w)
    else $error("no idle after terminate");
  a_frame_min: assert property (fb_w ##7 sfd_w |=> !pcs_ctl [*8])
    else $error("frame body cut short");
  a_ctl_legal: assert property (pcs_ctl |-> ctl_ok_w)
    else $error("unknown control character");
  a_err_at_eop: assert property (valid && error |-> eop)
    else $error("error request off end word");
endmodule : tx_frame_monitor

// [test_tx_mac_frame_encapsulator.sv]
// Testbench: packet source feeding the framing end, checks the byte stream.
// Assumes default parameters: standard gap, CRC insertion, no pass-through.
`timescale 1ns/10ps
`include "tx_frame_map.svh"
module test_tx_mac_frame_encapsulator import tx_frame_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [63:0] in_data = 64'h0;
  logic in_sop = 1'b0;
  logic in_eop = 1'b0;
  logic [2:0] in_empty = 3'h0;
  logic in_error = 1'b0;
  logic [7:0] pcs_byte;
  logic pcs_ctl;
  int fail_count = 0;
  int checks = 0;
  int lens [6] = '{9, 59, 60, 61, 70, 20};
  tx_client_if cif ();
  always #2 clk = ~clk;
  tx_packet_source i_tx_packet_source (.clk(clk), .rst(rst), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop),
    .in_empty(in_empty), .in_error(in_error), .cli(cif.source));
  tx_mac_frame_encapsulator i_tx_mac_frame_encapsulator (.clk(clk), .rst(rst),
    .cli(cif.sink), .pcs_byte(pcs_byte), .pcs_ctl(pcs_ctl));
  tx_frame_monitor i_tx_frame_monitor (.clk(clk), .rst(rst), .valid(cif.valid),
    .ready(cif.ready), .data(cif.data), .sop(cif.sop), .eop(cif.eop), .empty(cif.empty),
    .error(cif.error), .pcs_byte(pcs_byte), .pcs_ctl(pcs_ctl));
  function automatic logic [7:0] pat(int n, int i);
    return 8'(i * 7 + n * 13 + 1);
  endfunction : pat
  function automatic logic [31:0] crc_upd(logic [31:0] c, logic [7:0] b);
    c = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? (c >> 1) ^ `TX_CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc_upd
  task final_report;
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task check_sym(string what, logic [8:0] exp, logic [8:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_sym
  // Expected symbols after the start character, as {ctl, byte}
  task build(int n, output logic [8:0] e[$]);
    logic [31:0] c;
    e = {};
    c = `TX_CRC_INIT;
    repeat (6) e.push_back({1'b0, `TX_PRE_CHAR});
    e.push_back({1'b0, `TX_SFD_CHAR});
    for (int i = 0; i < lens[n]; i++) begin
      e.push_back({1'b0, pat(n, i)});
      c = crc_upd(c, pat(n, i));
    end
    if (n == 5) begin
      repeat (8) e.push_back({1'b1, `TX_ERR_CHAR});
      e.push_back({1'b1, `TX_IDLE_CHAR});
      return;
    end
    for (int i = lens[n]; i < 60; i++) begin
      e.push_back({1'b0, `TX_PAD_BYTE});
      c = crc_upd(c, `TX_PAD_BYTE);
    end
    c = ~c;
    for (int k = 0; k < 4; k++) e.push_back({1'b0, c[8*k +: 8]});
    e.push_back({1'b1, `TX_TERM_CHAR});
  endtask : build
  task send(int n);
    int words;
    int t;
    words = (lens[n] + 7) / 8;
    for (int w = 0; w < words; w++) begin
      @(negedge clk);
      in_valid = 1'b1;
      for (int k = 0; k < 8; k++) in_data[63-8*k -: 8] = pat(n, w * 8 + k);
      in_sop = (w == 0);
      in_eop = (w == words - 1);
      in_empty = 3'(words * 8 - lens[n]);
      in_error = (n == 5) && (w == words - 1);
      t = 0;
      #1;
      while (!in_ready && t < 300) begin
        @(negedge clk);
        #1;
        t++;
      end
      if (t >= 300) begin
        fail_count++;
        final_report();
      end
      @(posedge clk);
    end
    @(negedge clk);
    in_valid = 1'b0;
  endtask : send
  task recv(int n);
    logic [8:0] e[$];
    int t;
    build(n, e);
    t = 0;
    @(negedge clk);
    while (!(pcs_ctl === 1'b1 && pcs_byte === `TX_START_CHAR) && t < 400) begin
      @(negedge clk);
      t++;
    end
    check_sym("start", {1'b1, `TX_START_CHAR}, {pcs_ctl, pcs_byte});
    if (t >= 400) final_report();
    foreach (e[i]) begin
      @(negedge clk);
      check_sym("symbol", e[i], {pcs_ctl, pcs_byte});
    end
  endtask : recv
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check_sym("idle after reset", {1'b1, `TX_IDLE_CHAR}, {pcs_ctl, pcs_byte});
    check_sym("ready after reset", 9'h001, {8'h00, cif.ready});
    fork
      begin
        for (int n = 0; n < 6; n++) send(n);
      end
      begin
        for (int n = 0; n < 6; n++) recv(n);
      end
    join
    repeat (20) @(negedge clk);
    final_report();
  end
endmodule : test_tx_mac_frame_encapsulator
